// >>> cxs_cfg.svh
// Constants for the instruction execution subset: opcodes, status bits,
// register offsets, reset values and cycle counts.
// Assumes inclusion by bare name from design, checker and bench files.
`ifndef CXS_CFG_SVH
`define CXS_CFG_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CXS_OFF_CTRL 12'h000
`define CXS_OFF_INSTR 12'h004
`define CXS_OFF_WORK 12'h008
`define CXS_OFF_STATUS 12'h00C
`define CXS_OFF_PC 12'h010
`define CXS_OFF_FADDR 12'h014
`define CXS_OFF_FDATA 12'h018
`define CXS_OFF_WDOG 12'h01C
`define CXS_OFF_STACK 12'h020

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define CXS_ST_C 0
`define CXS_ST_DC 1
`define CXS_ST_Z 2
`define CXS_ST_PD_N 3
`define CXS_ST_TO_N 4

// ----------------------------------------
// Opcode patterns (14-bit word)
// ----------------------------------------
`define CXS_OP_RET 14'h0008
`define CXS_OP_SLEEP 14'h0063
`define CXS_OPH_LITERAL_RETURN_OP 4'hD
`define CXS_OPH_RRF 6'h0C
`define CXS_OPH_LITERAL_MINUS_WORK_OP 5'h1E
`define CXS_OPH_EXCLUSIVE_OR_LITERAL_OP 6'h3A

// ----------------------------------------
// Reset values, cycle counts and storage depths
// ----------------------------------------
`define CXS_RST_STATUS 5'h18
`define CXS_RST_PC 13'h0000
`define CXS_BRANCH_CYCLES 2
`define CXS_FILE_DEPTH 128
`define CXS_STACK_DEPTH 8

`endif

// >>> cxs_pkg.sv
// Types for the instruction execution subset.
// Assumes cxs_cfg.svh for numeric constants.
package cxs_pkg;
    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } cxs_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cxs_apb_rsp_t;

    typedef enum logic [2:0] {
        CXS_OPC_NONE = 3'b000,
        CXS_OPC_LRET = 3'b001,
        CXS_OPC_RRC = 3'b010,
        CXS_OPC_RET = 3'b011,
        CXS_OPC_SLEEP = 3'b100,
        CXS_OPC_LSUB = 3'b101,
        CXS_OPC_LXOR = 3'b110
    } cxs_opc_t;

    typedef enum logic [1:0] {
        CXS_ST_IDLE = 2'b00,
        CXS_ST_EXEC = 2'b01,
        CXS_ST_FLUSH = 2'b10,
        CXS_ST_ASLEEP = 2'b11
    } cxs_state_t;
endpackage : cxs_pkg

// >>> cxs_alu.sv
// Combinational datapath for the executed opcodes.
// Assumes operands are stable while the core sits in its execute state.
`timescale 1ns/1ps
`include "cxs_cfg.svh"
module cxs_alu (
    input wire cxs_pkg::cxs_opc_t opc, // Decoded operation
    input wire logic [7:0] lit, // Immediate operand
    input wire logic [7:0] work, // Working register
    input wire logic [7:0] fval, // Addressed file register
    input wire logic carry_in, // Current carry flag
    output logic [7:0] result, // Operation result
    output logic c_out, // New carry
    output logic dc_out, // New digit carry
    output logic z_out // New zero
);
    import cxs_pkg::*;
    logic [8:0] diff;
    logic [4:0] ndiff;

    always_comb begin
        diff = {1'b0, lit} + {1'b0, ~work} + 9'h001;
        ndiff = {1'b0, lit[3:0]} + {1'b0, ~work[3:0]} + 5'h01;
        result = lit;
        c_out = carry_in;
        dc_out = 1'b0;
        case (opc)
            CXS_OPC_LRET: result = lit;
            CXS_OPC_RRC: begin
                result = {carry_in, fval[7:1]};
                c_out = fval[0];
            end
            CXS_OPC_LSUB: begin
                result = diff[7:0];
                c_out = diff[8];
                dc_out = ndiff[4];
            end
            CXS_OPC_LXOR: result = work ^ lit;
            default: result = work;
        endcase
        z_out = (result == 8'h00);
    end
endmodule : cxs_alu

// >>> cxs_core.sv
// Executes a subset of an 8-bit core's instructions, fed over APB.
// Assumes one APB master; instruction written to INSTR starts execution.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "cxs_cfg.svh"
module cxs_core #(
    parameter int FILE_DEPTH = `CXS_FILE_DEPTH,
    parameter int STACK_DEPTH = `CXS_STACK_DEPTH
) (
    input wire logic core_clk, // 100 MHz clock
    input wire logic rst, // Sync reset, active high
    input wire cxs_pkg::cxs_apb_req_t apb_req, // APB request
    output cxs_pkg::cxs_apb_rsp_t apb_rsp, // APB response
    input wire logic wake, // Wake from sleep
    input wire logic wdog_tick, // Watchdog clock tick
    output logic sleeping, // Core asleep, oscillator halted
    output logic busy // Instruction executing
);
    import cxs_pkg::*;

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    // Seven-bit file select and three-bit wrapping stack pointer
    // leave no room for other depths
    if (FILE_DEPTH != 128 || STACK_DEPTH != 8) begin : g_bad_depth
        $error("cxs_core: unsupported depth");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    cxs_state_t state_r, state_nxt;
    logic [13:0] instr_r, instr_nxt;
    logic [7:0] work_r, work_nxt;
    logic [4:0] status_r, status_nxt;
    logic [12:0] pc_r, pc_nxt;
    logic [7:0] wdog_r, wdog_nxt;
    logic [7:0] presc_r, presc_nxt;
    logic [2:0] sp_r, sp_nxt;
    logic [12:0] stack_r [STACK_DEPTH];
    logic [12:0] push_val;
    logic push_en;
    logic [7:0] file_r [FILE_DEPTH];
    logic [6:0] faddr_r, faddr_nxt;
    logic file_we;
    logic [6:0] file_wa;
    logic [7:0] file_wd;
    logic [31:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    cxs_opc_t opc;
    logic [7:0] lit;
    logic [6:0] fsel;
    logic dbit;
    always_comb begin
        lit = instr_r[7:0];
        fsel = instr_r[6:0];
        dbit = instr_r[7];
        // Exact matches first; none of the prefix tests below covers either word
        if (instr_r == `CXS_OP_RET)
            opc = CXS_OPC_RET;
        else if (instr_r == `CXS_OP_SLEEP)
            opc = CXS_OPC_SLEEP;
        else if (instr_r[13:10] == `CXS_OPH_LITERAL_RETURN_OP)
            opc = CXS_OPC_LRET;
        else if (instr_r[13:8] == `CXS_OPH_RRF)
            opc = CXS_OPC_RRC;
        else if (instr_r[13:9] == `CXS_OPH_LITERAL_MINUS_WORK_OP)
            opc = CXS_OPC_LSUB;
        else if (instr_r[13:8] == `CXS_OPH_EXCLUSIVE_OR_LITERAL_OP)
            opc = CXS_OPC_LXOR;
        else
            opc = CXS_OPC_NONE;
    end

    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    logic [7:0] alu_res;
    logic alu_c, alu_dc, alu_z;
    cxs_alu u_alu (
        .opc(opc),
        .lit(lit),
        .work(work_r),
        .fval(file_r[fsel]),
        .carry_in(status_r[`CXS_ST_C]),
        .result(alu_res),
        .c_out(alu_c),
        .dc_out(alu_dc),
        .z_out(alu_z)
    );

    // ----------------------------------------
    // APB access
    // ----------------------------------------
    logic acc, wr, rd;
    logic [2:0] sp_dec;
    always_comb begin
        acc = apb_req.psel && apb_req.penable;
        wr = acc && apb_req.pwrite;
        rd = acc && !apb_req.pwrite;
        sp_dec = sp_r - 3'h1;
        // Zero wait states: every access ends at its first access edge
        apb_rsp.pready = 1'b1;
        apb_rsp.prdata = prdata_r;
        apb_rsp.pslverr = pslverr_r;
        sleeping = (state_r == CXS_ST_ASLEEP);
        busy = (state_r == CXS_ST_EXEC) || (state_r == CXS_ST_FLUSH);
    end

    // ----------------------------------------
    // APB response
    // ----------------------------------------
    // Read data and error are registered, so both are decoded in setup
    // and stand unchanged through the access edge.
    always_comb begin
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
            case (apb_req.paddr)
                `CXS_OFF_CTRL: prdata_nxt = {30'h0, busy, sleeping};
                `CXS_OFF_INSTR: prdata_nxt = {18'h0, instr_r};
                `CXS_OFF_WORK: prdata_nxt = {24'h0, work_r};
                `CXS_OFF_STATUS: prdata_nxt = {27'h0, status_r};
                `CXS_OFF_PC: prdata_nxt = {19'h0, pc_r};
                `CXS_OFF_FADDR: prdata_nxt = {25'h0, faddr_r};
                `CXS_OFF_FDATA: prdata_nxt = {24'h0, file_r[faddr_r]};
                `CXS_OFF_WDOG: prdata_nxt = {16'h0, presc_r, wdog_r};
                `CXS_OFF_STACK: prdata_nxt = {16'h0, 5'h0, sp_r, 8'h0};
                default: prdata_nxt = 32'h0;
            endcase
        end

        if (apb_req.psel && !apb_req.penable) begin
            case (apb_req.paddr)
                `CXS_OFF_CTRL,
                `CXS_OFF_INSTR,
                `CXS_OFF_WORK,
                `CXS_OFF_STATUS,
                `CXS_OFF_PC,
                `CXS_OFF_FADDR,
                `CXS_OFF_FDATA,
                `CXS_OFF_WDOG,
                `CXS_OFF_STACK: pslverr_nxt = 1'b0;
                default: pslverr_nxt = 1'b1;
            endcase
        end
    end

    // ----------------------------------------
    // Execution
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        instr_nxt = instr_r;
        work_nxt = work_r;
        status_nxt = status_r;
        pc_nxt = pc_r;
        wdog_nxt = wdog_r;
        presc_nxt = presc_r;
        sp_nxt = sp_r;
        faddr_nxt = faddr_r;
        push_en = 1'b0;
        push_val = 13'h0000;
        file_we = 1'b0;
        file_wa = faddr_r;
        file_wd = apb_req.pwdata[7:0];
        // Watchdog clock is off while halted
        if (wdog_tick && state_r != CXS_ST_ASLEEP) begin
            {wdog_nxt, presc_nxt} = {wdog_r, presc_r} + 16'h0001;
        end
        // Register writes are ignored while executing
        if (wr && state_r == CXS_ST_IDLE) begin
            case (apb_req.paddr)
                `CXS_OFF_INSTR: begin
                    instr_nxt = apb_req.pwdata[13:0];
                    state_nxt = CXS_ST_EXEC;
                end
                `CXS_OFF_WORK: work_nxt = apb_req.pwdata[7:0];
                `CXS_OFF_STATUS: status_nxt = apb_req.pwdata[4:0];
                `CXS_OFF_PC: pc_nxt = apb_req.pwdata[12:0];
                `CXS_OFF_FADDR: faddr_nxt = apb_req.pwdata[6:0];
                `CXS_OFF_FDATA: file_we = 1'b1;
                `CXS_OFF_STACK: begin
                    push_en = 1'b1;
                    push_val = apb_req.pwdata[12:0];
                    sp_nxt = sp_r + 3'h1;
                end
                default: ;
            endcase
        end
        case (state_r)
            CXS_ST_IDLE: ;
            CXS_ST_EXEC: begin
                pc_nxt = pc_r + 13'h0001;
                state_nxt = CXS_ST_IDLE;
                case (opc)
                    CXS_OPC_LRET, CXS_OPC_RET: begin
                        if (opc == CXS_OPC_LRET)
                            work_nxt = alu_res;
                        // Pointer wraps; popping an empty stack reads a stale entry
                        pc_nxt = stack_r[sp_dec];
                        sp_nxt = sp_dec;
                        state_nxt = CXS_ST_FLUSH;
                    end
                    CXS_OPC_RRC: begin
                        status_nxt[`CXS_ST_C] = alu_c;
                        if (dbit) begin
                            file_we = 1'b1;
                            file_wa = fsel;
                            file_wd = alu_res;
                        end else begin
                            work_nxt = alu_res;
                        end
                    end
                    CXS_OPC_SLEEP: begin
                        wdog_nxt = 8'h00;
                        presc_nxt = 8'h00;
                        status_nxt[`CXS_ST_PD_N] = 1'b0;
                        status_nxt[`CXS_ST_TO_N] = 1'b1;
                        state_nxt = CXS_ST_ASLEEP;
                    end
                    CXS_OPC_LSUB: begin
                        work_nxt = alu_res;
                        status_nxt[`CXS_ST_C] = alu_c;
                        status_nxt[`CXS_ST_DC] = alu_dc;
                        status_nxt[`CXS_ST_Z] = alu_z;
                    end
                    CXS_OPC_LXOR: begin
                        work_nxt = alu_res;
                        status_nxt[`CXS_ST_Z] = alu_z;
                    end
                    default: ;
                endcase
            end
            CXS_ST_FLUSH: begin
                // Discarded fetch slot of a return
                state_nxt = CXS_ST_IDLE;
            end
            CXS_ST_ASLEEP: begin
                // Nothing advances while halted
                if (wake)
                    state_nxt = CXS_ST_IDLE;
            end
            default: state_nxt = CXS_ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= CXS_ST_IDLE;
            instr_r <= 14'h0000;
            work_r <= 8'h00;
            status_r <= `CXS_RST_STATUS;
            pc_r <= `CXS_RST_PC;
            wdog_r <= 8'h00;
            presc_r <= 8'h00;
            sp_r <= 3'h0;
            faddr_r <= 7'h00;
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            instr_r <= instr_nxt;
            work_r <= work_nxt;
            status_r <= status_nxt;
            pc_r <= pc_nxt;
            wdog_r <= wdog_nxt;
            presc_r <= presc_nxt;
            sp_r <= sp_nxt;
            faddr_r <= faddr_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // Storage has no reset; software initialises it
    always_ff @(posedge core_clk) begin
        if (file_we)
            file_r[file_wa] <= file_wd;
        if (push_en)
            stack_r[sp_r] <= push_val;
    end
endmodule : cxs_core

// >>> cxs_core_sva.sv
// Checker for the execution core: busy timing of returns and sleep entry and exit.
// Assumes binding to cxs_core; sees only that module's ports.
`timescale 1ns/1ps
`include "cxs_cfg.svh"
module cxs_core_sva
    import cxs_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst, // Sync reset
    input wire cxs_pkg::cxs_apb_req_t apb_req, // APB request
    input wire cxs_pkg::cxs_apb_rsp_t apb_rsp, // APB response
    input wire logic wake, // Wake level
    input wire logic wdog_tick, // Watchdog tick
    input wire logic sleeping, // Asleep
    input wire logic busy // Executing
);
    // ----------------------------------------
    // Accepted instruction write
    // ----------------------------------------
    logic go;
    assign go = apb_req.psel && apb_req.penable && apb_req.pwrite && !busy && !sleeping
        && apb_req.paddr == `CXS_OFF_INSTR;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_return_two_cycles: assert property (go && apb_req.pwdata[13:0] == `CXS_OP_RET
        |=> busy [*2]) else $error("return did not hold busy two cycles");
    a_lit_return_two: assert property (go && apb_req.pwdata[13:10] == 4'hD
        |=> busy [*2]) else $error("literal return did not take two cycles");
    a_sleep_enters: assert property (go && apb_req.pwdata[13:0] == `CXS_OP_SLEEP
        |-> ##[1:3] sleeping) else $error("sleep not entered");
    a_sleep_holds: assert property (sleeping && !wake |=> sleeping)
        else $error("left sleep without wake");
    a_asleep_no_exec: assert property (sleeping |-> !busy)
        else $error("executing while asleep");
    a_wake_leaves: assert property (sleeping && wake |-> ##[1:2] !sleeping)
        else $error("wake ignored");
    a_busy_bounded: assert property ($rose(busy) |-> ##[1:3] !busy)
        else $error("busy too long");
    a_pready_high: assert property (apb_req.psel |-> apb_rsp.pready)
        else $error("wait state inserted");

    c_return: cover property (go && apb_req.pwdata[13:0] == `CXS_OP_RET);
    c_sleep: cover property ($rose(sleeping));
    c_wake: cover property ($fell(sleeping));
endmodule : cxs_core_sva

bind cxs_core cxs_core_sva u_sva (.core_clk(core_clk), .rst(rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .wake(wake), .wdog_tick(wdog_tick), .sleeping(sleeping), .busy(busy));

// >>> testbench.sv
// Self-checking bench for the execution core, driving it over APB.
// Assumes cxs_core with zero-wait APB and a polled busy bit in CTRL.
`timescale 1ns/1ps
`include "cxs_cfg.svh"
module testbench;
    import cxs_pkg::*;
    logic core_clk;
    logic rst;
    cxs_apb_req_t apb_req;
    cxs_apb_rsp_t apb_rsp;
    logic wake;
    logic wdog_tick;
    logic sleeping;
    logic busy;
    int mismatches;
    int samples_checked;
    logic [31:0] rd;
    logic err;
    logic [4:0] st; // Expected {to_n, pd_n, z, dc, c}

    cxs_core uut (.core_clk(core_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .wake(wake), .wdog_tick(wdog_tick), .sleeping(sleeping), .busy(busy));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic report_and_stop;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int n;
        @(posedge core_clk);
        apb_req.paddr <= addr;
        apb_req.pwrite <= wr;
        apb_req.pwdata <= wd;
        apb_req.psel <= 1'b1;
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        if (apb_rsp.pready !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    // Polls busy; a refused write still finishes at once
    task automatic run(input logic [13:0] op);
        int n;
        apb(1'b1, `CXS_OFF_INSTR, {18'h0, op});
        n = 0;
        do begin
            apb(1'b0, `CXS_OFF_CTRL, 32'h0);
            n++;
        end while (rd[1] !== 1'b0 && n < 20);
        if (rd[1] !== 1'b0) begin
            mismatches++;
            report_and_stop();
        end
    endtask : run

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_returns;
        rdchk(`CXS_OFF_STATUS, {27'h0, st});
        rdchk(`CXS_OFF_PC, 32'h0);
        rdchk(12'hFFC, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, `CXS_OFF_STACK, 32'h111);
        apb(1'b1, `CXS_OFF_STACK, 32'h222);
        apb(1'b1, `CXS_OFF_STACK, 32'h0A5);
        run(14'h34A5);
        rdchk(`CXS_OFF_WORK, 32'hA5);
        rdchk(`CXS_OFF_PC, 32'h0A5);
        run(`CXS_OP_RET);
        rdchk(`CXS_OFF_PC, 32'h222);
        run(`CXS_OP_RET);
        rdchk(`CXS_OFF_PC, 32'h111);
        chk({31'h0, err}, 32'h0);
        rdchk(`CXS_OFF_WORK, 32'hA5);
        rdchk(`CXS_OFF_STATUS, {27'h0, st});
    endtask : t_returns

    task automatic t_xor;
        run(14'h3AFF);
        rdchk(`CXS_OFF_WORK, 32'h5A);
        rdchk(`CXS_OFF_STATUS, {27'h0, st});
        run(14'h3A5A);
        st[2] = 1'b1;
        rdchk(`CXS_OFF_WORK, 32'h00);
        rdchk(`CXS_OFF_STATUS, {27'h0, st});
    endtask : t_xor

    task automatic t_sub;
        logic [15:0] cases [4] = '{16'h0503, 16'h0305, 16'h1001, 16'h2222};
        logic [7:0] k;
        logic [7:0] w;
        for (int i = 0; i < 4; i++) begin
            k = cases[i][15:8];
            w = cases[i][7:0];
            apb(1'b1, `CXS_OFF_WORK, {24'h0, w});
            run({6'h3C, k});
            st[0] = k >= w;
            st[1] = k[3:0] >= w[3:0];
            st[2] = k == w;
            rdchk(`CXS_OFF_WORK, {24'h0, k - w});
            rdchk(`CXS_OFF_STATUS, {27'h0, st});
        end
    endtask : t_sub

    task automatic t_rrf;
        apb(1'b1, `CXS_OFF_FADDR, 32'h21);
        apb(1'b1, `CXS_OFF_FDATA, 32'h81);
        run(14'h0CA1);
        rdchk(`CXS_OFF_FDATA, 32'hC0);
        rdchk(`CXS_OFF_WORK, 32'h00);
        rdchk(`CXS_OFF_STATUS, {27'h0, st});
        run(14'h0C21);
        st[0] = 1'b0;
        rdchk(`CXS_OFF_WORK, 32'hE0);
        rdchk(`CXS_OFF_FDATA, 32'hC0);
        rdchk(`CXS_OFF_STATUS, {27'h0, st});
    endtask : t_rrf

    task automatic t_sleep;
        wdog_tick <= 1'b1;
        repeat (5) @(posedge core_clk);
        wdog_tick <= 1'b0;
        apb(1'b0, `CXS_OFF_WDOG, 32'h0);
        chk(rd, 32'h00000500);
        run(`CXS_OP_SLEEP);
        st[3] = 1'b0;
        rdchk(`CXS_OFF_CTRL, 32'h1);
        chk({30'h0, busy, sleeping}, 32'h1);
        rdchk(`CXS_OFF_WDOG, 32'h0);
        rdchk(`CXS_OFF_STATUS, {27'h0, st});
        apb(1'b1, `CXS_OFF_INSTR, 32'h3AFF);
        rdchk(`CXS_OFF_WORK, 32'hE0);
        wake <= 1'b1;
        repeat (3) @(posedge core_clk);
        wake <= 1'b0;
        rdchk(`CXS_OFF_CTRL, 32'h0);
        chk({30'h0, busy, sleeping}, 32'h0);
    endtask : t_sleep

    initial begin
        rst = 1'b1;
        apb_req = '0;
        wake = 1'b0;
        wdog_tick = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        st = `CXS_RST_STATUS;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        t_returns();
        t_xor();
        t_sub();
        t_rrf();
        t_sleep();
        report_and_stop();
    end
endmodule : testbench
